// [drive_alarm_pkg.sv]
/*
  Shared constants for the drive alarm monitor: register map, control
  field positions, alarm bit numbers, save sequencer states.
  Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
package drive_alarm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] LEVEL_ADDR  = 8'h04;
  localparam logic [7:0] STILL_ADDR  = 8'h08;
  localparam logic [7:0] STATUS_ADDR = 8'h0c;
  localparam logic [7:0] FIRST_ADDR  = 8'h10;
  localparam logic [7:0] SAVES_ADDR  = 8'h14;

  // ----------------------------------------------------------------
  // Control fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_SEL_AV    = 0;
  localparam int CTRL_SFB_INH   = 1;
  localparam int CTRL_TACH_SEL  = 2;
  localparam int CTRL_NET_EN    = 3;
  localparam int CTRL_FIELD_EN  = 4;
  localparam int CTRL_AUTOTUNE  = 5;
  localparam int CTRL_W         = 6;
  localparam logic [5:0]  CTRL_RST  = 6'h01;
  localparam logic [15:0] LEVEL_RST = 16'h0800;
  localparam logic [15:0] STILL_RST = 16'h0020;

  // ----------------------------------------------------------------
  // Alarm bits, one per alarm, numbered as the display list minus one
  // ----------------------------------------------------------------
  localparam int AL_SUPPLY   = 5;
  localparam int AL_SYNC     = 6;
  localparam int AL_TACH     = 7;
  localparam int AL_SPDFBK   = 8;
  localparam int AL_STACK    = 9;
  localparam int AL_CALCARD  = 10;
  localparam int AL_NETWORK  = 11;
  localparam int AL_AUTOTUNE = 12;
  localparam int AL_FIELD_OC = 13;
  localparam int AL_ARM_OV   = 14;
  localparam int AL_OVERSPD  = 15;
  localparam int AL_W        = 16;

  // ----------------------------------------------------------------
  // Lock range, supply frequency in centihertz; 110 percent limit
  // ----------------------------------------------------------------
  localparam logic [15:0] FREQ_MIN_CHZ = 16'd4500;
  localparam logic [15:0] FREQ_MAX_CHZ = 16'd6500;
  localparam logic [4:0]  OVER_NUM     = 5'd11;
  localparam logic [4:0]  OVER_DEN     = 5'd10;

  // ----------------------------------------------------------------
  // Status fields
  // ----------------------------------------------------------------
  localparam int ST_LATCHED  = 16;
  localparam int ST_HEALTH   = 17;
  localparam int ST_CONTACT  = 18;
  localparam int ST_LOCKED   = 19;
  localparam int ST_SAVING   = 20;

  typedef enum logic [1:0] {
    MENU_OFF = 2'b00,
    MENU_PROMPT = 2'b01,
    MENU_SAVING = 2'b10
  } menu_state_t;

endpackage : drive_alarm_pkg

// [drive_alarm_monitor.sv]
/*
  Drive alarm monitor: evaluates alarm conditions on each control sample,
  latches the first failure into the health logic, drives the start
  contactor and firing enable, and sequences a background parameter save.
  Assumes measurement words and sample_i come from logic on clk_i; pins
  and keys are asynchronous; the memory writer answers with nvm_done_i.
*/
// Function
// - Supply loss alarms only while contactor energised
// - Reset with persisting fault re-trips contactor
// - Lock firing to 45..65 Hz supply automatically
// - Sync alarm when out of range or unlocked
// - Tach alarm on tach or fibre failure
// - Speed feedback versus armature voltage beyond level
// - Speed feedback alarm suppressed by AV or inhibit
// - Stack alarm when heatsink switch open
// - No restart while heatsink switch open
// - Cal card alarm on start if absent
// - Network alarm on traffic or interface failure
// - Autotune alarm if motor rotates
// - Field overcurrent above 110% when regulator on
// - Armature overvoltage above 110% of expected
// - Overspeed above 110% of expected
// - Raise saves, saving shown, prompt back, exit leaves
// - Save runs in background, drive unaffected
// - Unlimited repeated saves rewrite parameters
// - Latch first alarm only, clear on restart
// - Alarms shown always, latched only when energised
// - Tach and network alarms off when unselected
`timescale 1ns/1ps
module drive_alarm_monitor (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Measurements, same clock
  input  wire logic        sample_i,
  input  wire logic [15:0] supply_freq_i,
  input  wire logic [15:0] speed_fbk_i,
  input  wire logic [15:0] speed_expected_i,
  input  wire logic [15:0] armature_voltage_i,
  input  wire logic [15:0] av_expected_i,
  input  wire logic [15:0] field_current_i,
  input  wire logic [15:0] field_cal_i,
  // Asynchronous pins
  input  wire logic        supply_ok_i,
  input  wire logic        sync_ok_i,
  input  wire logic        tach_ok_i,
  input  wire logic        fibre_ok_i,
  input  wire logic        stack_switch_open_i,
  input  wire logic        cal_card_in_i,
  input  wire logic        net_rx_ok_i,
  input  wire logic        net_if_ok_i,
  input  wire logic        contactor_fb_i,
  input  wire logic        start_i,
  input  wire logic        key_menu_i,
  input  wire logic        key_raise_i,
  input  wire logic        key_exit_i,
  // Memory writer, same clock
  input  wire logic        nvm_done_i,
  // Outputs
  output logic             nvm_start_o,
  output logic             save_prompt_o,
  output logic             saving_o,
  output logic             health_o,
  output logic             contactor_o,
  output logic             fire_en_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int NPIN = 13;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_m_q;
  logic [NPIN-1:0] pin_q;
  logic [2:0]      key_d1_q;

  assign pin_raw = {key_exit_i, key_raise_i, key_menu_i, start_i,
                    contactor_fb_i, net_if_ok_i, net_rx_ok_i, cal_card_in_i,
                    stack_switch_open_i, fibre_ok_i, tach_ok_i, sync_ok_i,
                    supply_ok_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_m_q <= '0;
      pin_q   <= '0;
    end else begin
      pin_m_q <= pin_raw;
      pin_q   <= pin_m_q;
    end
  end

  wire s_supply_ok  = pin_q[0];
  wire s_sync_ok    = pin_q[1];
  wire s_tach_ok    = pin_q[2];
  wire s_fibre_ok   = pin_q[3];
  wire s_stack_open = pin_q[4];
  wire s_cal_in     = pin_q[5];
  wire s_net_rx_ok  = pin_q[6];
  wire s_net_if_ok  = pin_q[7];
  wire s_energised  = pin_q[8];
  wire s_start      = pin_q[9];
  wire [2:0] s_keys = pin_q[12:10];

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic over_110(input logic [15:0] meas,
                                    input logic [15:0] ref_v);
    logic [20:0] lhs;
    logic [20:0] rhs;
    lhs = 21'(meas) * 21'(drive_alarm_pkg::OVER_DEN);
    rhs = 21'(ref_v) * 21'(drive_alarm_pkg::OVER_NUM);
    return lhs > rhs;
  endfunction : over_110

  function automatic logic [15:0] abs_diff(input logic [15:0] a,
                                           input logic [15:0] b);
    return (a > b) ? a - b : b - a;
  endfunction : abs_diff

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [drive_alarm_pkg::CTRL_W-1:0] ctrl_q;
  logic [15:0] level_q;
  logic [15:0] still_q;
  logic [15:0] alarm_q;
  logic        latched_q;
  logic [3:0]  first_q;
  logic [15:0] saves_q;
  logic        start_q;
  logic        run_q;
  logic        cal_trip_q;
  logic        locked_q;
  drive_alarm_pkg::menu_state_t menu_q;

  wire bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr   = bus_req & wb_we_i;
  wire wr_ctrl  = bus_wr & (wb_adr_i == drive_alarm_pkg::CTRL_ADDR) & wb_sel_i[0];
  wire wr_lvl_l = bus_wr & (wb_adr_i == drive_alarm_pkg::LEVEL_ADDR) & wb_sel_i[0];
  wire wr_lvl_h = bus_wr & (wb_adr_i == drive_alarm_pkg::LEVEL_ADDR) & wb_sel_i[1];
  wire wr_stl_l = bus_wr & (wb_adr_i == drive_alarm_pkg::STILL_ADDR) & wb_sel_i[0];
  wire wr_stl_h = bus_wr & (wb_adr_i == drive_alarm_pkg::STILL_ADDR) & wb_sel_i[1];

  logic [31:0] status_w;
  logic [31:0] rd_mux;
  assign status_w = {11'h000, menu_q == drive_alarm_pkg::MENU_SAVING, locked_q,
                     contactor_o, health_o, latched_q, alarm_q};

  always_comb begin
    unique case (wb_adr_i)
      drive_alarm_pkg::CTRL_ADDR:   rd_mux = {26'h0000000, ctrl_q};
      drive_alarm_pkg::LEVEL_ADDR:  rd_mux = {16'h0000, level_q};
      drive_alarm_pkg::STILL_ADDR:  rd_mux = {16'h0000, still_q};
      drive_alarm_pkg::STATUS_ADDR: rd_mux = status_w;
      drive_alarm_pkg::FIRST_ADDR:  rd_mux = {27'h0000000, latched_q, first_q};
      drive_alarm_pkg::SAVES_ADDR:  rd_mux = {16'h0000, saves_q};
      default:                      rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_q   <= drive_alarm_pkg::CTRL_RST;
      level_q  <= drive_alarm_pkg::LEVEL_RST;
      still_q  <= drive_alarm_pkg::STILL_RST;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_mux : 32'h00000000;
      if (wr_ctrl)  ctrl_q        <= wb_dat_i[drive_alarm_pkg::CTRL_W-1:0];
      if (wr_lvl_l) level_q[7:0]  <= wb_dat_i[7:0];
      if (wr_lvl_h) level_q[15:8] <= wb_dat_i[15:8];
      if (wr_stl_l) still_q[7:0]  <= wb_dat_i[7:0];
      if (wr_stl_h) still_q[15:8] <= wb_dat_i[15:8];
    end
  end

  // ----------------------------------------------------------------
  // Alarm evaluation
  // ----------------------------------------------------------------
  wire sel_av   = ctrl_q[drive_alarm_pkg::CTRL_SEL_AV];
  wire sfb_inh  = ctrl_q[drive_alarm_pkg::CTRL_SFB_INH];
  wire tach_sel = ctrl_q[drive_alarm_pkg::CTRL_TACH_SEL];
  wire net_en   = ctrl_q[drive_alarm_pkg::CTRL_NET_EN];
  wire field_en = ctrl_q[drive_alarm_pkg::CTRL_FIELD_EN];
  wire tune_run = ctrl_q[drive_alarm_pkg::CTRL_AUTOTUNE];

  wire freq_ok  = (supply_freq_i >= drive_alarm_pkg::FREQ_MIN_CHZ) &&
                  (supply_freq_i <= drive_alarm_pkg::FREQ_MAX_CHZ);
  wire start_rise = s_start & ~start_q;

  logic [15:0] alarm_d;
  always_comb begin
    alarm_d = alarm_q;
    if (sample_i) begin
      alarm_d = 16'h0000;
      alarm_d[drive_alarm_pkg::AL_SUPPLY]   = s_energised & ~s_supply_ok;
      alarm_d[drive_alarm_pkg::AL_SYNC]     = ~(freq_ok & s_sync_ok);
      alarm_d[drive_alarm_pkg::AL_TACH]     = tach_sel & ~(s_tach_ok & s_fibre_ok);
      alarm_d[drive_alarm_pkg::AL_SPDFBK]   = ~sel_av & ~sfb_inh &
          (abs_diff(speed_fbk_i, armature_voltage_i) > level_q);
      alarm_d[drive_alarm_pkg::AL_STACK]    = s_stack_open;
      alarm_d[drive_alarm_pkg::AL_CALCARD]  = cal_trip_q;
      alarm_d[drive_alarm_pkg::AL_NETWORK]  = net_en & ~(s_net_rx_ok & s_net_if_ok);
      alarm_d[drive_alarm_pkg::AL_AUTOTUNE] = tune_run & (speed_fbk_i > still_q);
      alarm_d[drive_alarm_pkg::AL_FIELD_OC] = field_en & over_110(field_current_i, field_cal_i);
      alarm_d[drive_alarm_pkg::AL_ARM_OV]   = over_110(armature_voltage_i, av_expected_i);
      alarm_d[drive_alarm_pkg::AL_OVERSPD]  = over_110(speed_fbk_i, speed_expected_i);
    end
  end

  // Lowest numbered active alarm wins when two arrive together
  logic [3:0] first_d;
  always_comb begin
    first_d = 4'h0;
    for (int i = drive_alarm_pkg::AL_W - 1; i >= 0; i--) begin
      if (alarm_q[i]) begin
        first_d = 4'(i);
      end
    end
  end

  wire trip = s_energised & (|alarm_q) & ~latched_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_q    <= 16'h0000;
      start_q    <= 1'b0;
      cal_trip_q <= 1'b0;
      latched_q  <= 1'b0;
      first_q    <= 4'h0;
      locked_q   <= 1'b0;
    end else begin
      alarm_q  <= alarm_d;
      start_q  <= s_start;
      locked_q <= freq_ok & s_sync_ok;
      if (start_rise) begin
        cal_trip_q <= ~s_cal_in;
      end else if (~s_start) begin
        cal_trip_q <= 1'b0;
      end
      // A trip in the restart cycle must not be lost
      if (trip) begin
        latched_q <= 1'b1;
        first_q   <= first_d;
      end else if (start_rise) begin
        latched_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Health and contactor
  // ----------------------------------------------------------------
  wire run_d = start_rise ? ~s_stack_open : (run_q & s_start);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q       <= 1'b0;
      health_o    <= 1'b1;
      contactor_o <= 1'b0;
      fire_en_o   <= 1'b0;
    end else begin
      run_q       <= run_d;
      health_o    <= ~(latched_q | trip);
      contactor_o <= run_d & ~latched_q & ~trip & ~start_rise | run_d & start_rise;
      fire_en_o   <= contactor_o & locked_q & ~latched_q & ~trip;
    end
  end

  // ----------------------------------------------------------------
  // Parameter save sequencer
  // ----------------------------------------------------------------
  wire [2:0] key_rise = s_keys & ~key_d1_q;
  drive_alarm_pkg::menu_state_t menu_d;

  always_comb begin
    menu_d = menu_q;
    unique case (menu_q)
      drive_alarm_pkg::MENU_OFF: begin
        if (key_rise[0]) menu_d = drive_alarm_pkg::MENU_PROMPT;
      end
      drive_alarm_pkg::MENU_PROMPT: begin
        if (key_rise[2]) begin
          menu_d = drive_alarm_pkg::MENU_OFF;
        end else if (key_rise[1]) begin
          menu_d = drive_alarm_pkg::MENU_SAVING;
        end
      end
      drive_alarm_pkg::MENU_SAVING: begin
        if (nvm_done_i) menu_d = drive_alarm_pkg::MENU_PROMPT;
      end
      default: menu_d = drive_alarm_pkg::MENU_OFF;
    endcase
  end

  wire save_go = (menu_q == drive_alarm_pkg::MENU_PROMPT) &
                 (menu_d == drive_alarm_pkg::MENU_SAVING);

  // Save path touches no drive control state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      menu_q        <= drive_alarm_pkg::MENU_OFF;
      key_d1_q      <= 3'h0;
      nvm_start_o   <= 1'b0;
      save_prompt_o <= 1'b0;
      saving_o      <= 1'b0;
      saves_q       <= 16'h0000;
    end else begin
      menu_q        <= menu_d;
      key_d1_q      <= s_keys;
      nvm_start_o   <= save_go;
      save_prompt_o <= menu_d == drive_alarm_pkg::MENU_PROMPT;
      saving_o      <= menu_d == drive_alarm_pkg::MENU_SAVING;
      if (save_go) saves_q <= saves_q + 16'h0001;
    end
  end

endmodule : drive_alarm_monitor

// [drive_alarm_properties.sv]
/* Port checker for drive_alarm_monitor, bound to the design.
   Assumes one clock and the synchronous active-high reset. */
`timescale 1ns/1ps
module drive_alarm_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        stack_switch_open_i,
  input wire logic        nvm_done_i,
  input wire logic        nvm_start_o,
  input wire logic        save_prompt_o,
  input wire logic        saving_o,
  input wire logic        health_o,
  input wire logic        contactor_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ------------------------------------------------------------
  // Relations
  // ------------------------------------------------------------
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data outside ack");
  reset_state_a: assert property (disable iff (1'b0) rst_i |=> health_o && !contactor_o)
    else $error("reset state wrong");
  trip_drop_a: assert property ($fell(health_o) |-> ##[0:1] !contactor_o)
    else $error("contactor kept after trip");
  stack_block_a: assert property (stack_switch_open_i [*4] |-> !$rose(contactor_o))
    else $error("restart with stack open");
  save_start_a: assert property (nvm_start_o |-> saving_o && !save_prompt_o)
    else $error("save start without saving");
  save_pulse_a: assert property (nvm_start_o |=> !nvm_start_o)
    else $error("save start not a pulse");
  save_done_a: assert property (saving_o && nvm_done_i |=> !saving_o && save_prompt_o)
    else $error("prompt not back after save");
  save_hold_a: assert property (saving_o && !nvm_done_i |=> saving_o)
    else $error("saving dropped early");
  trip_c: cover property ($fell(health_o));
  energise_c: cover property ($rose(contactor_o));
  save_c: cover property (nvm_start_o);
endmodule : drive_alarm_checker

bind drive_alarm_monitor drive_alarm_checker chk (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .stack_switch_open_i,
  .nvm_done_i, .nvm_start_o, .save_prompt_o, .saving_o, .health_o, .contactor_o
);

// [drive_far_side.sv]
/* Far side of the alarm monitor: contactor relay and parameter memory.
   Assumes the monitor's clock and reset; slow_i picks a long write. */
`timescale 1ns/1ps
module drive_far_side (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic slow_i,
  input  wire logic contactor_i,
  input  wire logic save_start_i,
  output logic      contactor_fb_o,
  output logic      save_done_o
);
  logic [1:0] relay_q;
  logic [6:0] cnt_q;
  assign contactor_fb_o = relay_q[1];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      relay_q     <= 2'h0;
      cnt_q       <= 7'h00;
      save_done_o <= 1'b0;
    end else begin
      relay_q     <= {relay_q[0], contactor_i};
      save_done_o <= (cnt_q == 7'h01);
      if (save_start_i) begin
        cnt_q <= slow_i ? 7'h28 : 7'h10;
      end else if (cnt_q != 7'h00) begin
        cnt_q <= cnt_q - 7'h01;
      end
    end
  end
endmodule : drive_far_side

// [tb.sv]
/* Self-checking bench for drive_alarm_monitor.
   Pins and Wishbone change at the rising edge; drive_far_side answers. */
`timescale 1ns/1ps
module tb;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sample_i, slow;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [15:0] supply_freq_i, speed_fbk_i, speed_expected_i, armature_voltage_i;
  logic [15:0] av_expected_i, field_current_i, field_cal_i;
  logic        supply_ok_i, sync_ok_i, tach_ok_i, fibre_ok_i, stack_switch_open_i;
  logic        cal_card_in_i, net_rx_ok_i, net_if_ok_i, contactor_fb_i, start_i;
  logic        nvm_done_i, nvm_start_o, save_prompt_o, saving_o, health_o, contactor_o;
  logic        fire_en_o;
  logic [2:0]  keys;
  int          error_cnt, check_count;
  int          act[24] = '{0, 1, 2, 2, 2, 2, 3, 4, 3, 5, 5, 5, 6, 7, 8, 7, 9, 9, 10, 10, 5, 5, 0, 11};
  logic [15:0] val[24] = '{16'h0, 16'h0, 16'h1193, 16'h1965, 16'h1194, 16'h1964, 16'h0, 16'h0,
    16'h0, 16'h03b7, 16'h03b7, 16'h03b7, 16'h0, 16'h0, 16'h0, 16'h0, 16'h044d, 16'h044d,
    16'h0ce5, 16'h0ce4, 16'h0ce5, 16'h0ce4, 16'h0, 16'h0};
  logic [7:0]  ctl[24] = '{8'h1c, 8'h1c, 8'h1c, 8'h1c, 8'h1c, 8'h1c, 8'h1c, 8'h1c, 8'h18,
    8'h1c, 8'h1d, 8'h1e, 8'h1c, 8'h1c, 8'h1c, 8'h14, 8'h1c, 8'h0c, 8'h1c, 8'h1c, 8'h1c,
    8'h1c, 8'h3c, 8'h1c};
  logic [15:0] exp[24] = '{16'h0, 16'h0040, 16'h0040, 16'h0040, 16'h0, 16'h0, 16'h0080,
    16'h0080, 16'h0, 16'h0100, 16'h0, 16'h0, 16'h0200, 16'h0800, 16'h0800, 16'h0, 16'h2000,
    16'h0, 16'h4000, 16'h0, 16'h8000, 16'h0, 16'h1000, 16'h0};

  drive_alarm_monitor uut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .sample_i, .supply_freq_i, .speed_fbk_i, .speed_expected_i, .armature_voltage_i,
    .av_expected_i, .field_current_i, .field_cal_i, .supply_ok_i, .sync_ok_i, .tach_ok_i,
    .fibre_ok_i, .stack_switch_open_i, .cal_card_in_i, .net_rx_ok_i, .net_if_ok_i,
    .contactor_fb_i, .start_i, .key_menu_i(keys[0]), .key_raise_i(keys[1]),
    .key_exit_i(keys[2]), .nvm_done_i, .nvm_start_o, .save_prompt_o, .saving_o, .health_o,
    .contactor_o, .fire_en_o
  );
  drive_far_side model (
    .clk_i, .rst_i, .slow_i(slow), .contactor_i(contactor_o), .save_start_i(nvm_start_o),
    .contactor_fb_o(contactor_fb_i), .save_done_o(nvm_done_i)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    cyc(1);
  endtask : xfer

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] want);
    xfer(1'b0, a, 32'h0);
    chk(what, rd & m, want);
  endtask : rchk

  task automatic smp();
    cyc(3);
    sample_i <= 1'b1;
    cyc(1);
    sample_i <= 1'b0;
    cyc(4);
  endtask : smp

  task automatic good();
    {supply_ok_i, sync_ok_i, tach_ok_i, fibre_ok_i, net_rx_ok_i, net_if_ok_i} <= 6'h3f;
    {stack_switch_open_i, cal_card_in_i} <= 2'h1;
    supply_freq_i <= 16'h1388;
    {speed_fbk_i, speed_expected_i} <= {16'h0bb8, 16'h0bb8};
    {armature_voltage_i, av_expected_i} <= {16'h0bb8, 16'h0bb8};
    {field_current_i, field_cal_i} <= {16'h03e8, 16'h03e8};
    cyc(1);
  endtask : good

  task automatic restart();
    start_i <= 1'b0;
    smp();
    start_i <= 1'b1;
    cyc(8);
  endtask : restart

  task automatic press(input int k);
    keys[k] <= 1'b1;
    cyc(4);
    keys[k] <= 1'b0;
    cyc(4);
  endtask : press

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    cyc(30000);
    error_cnt++;
    $display("watchdog expired");
    end_of_test();
  end

  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, sample_i, slow, start_i} <= 7'h40;
    {wb_adr_i, wb_sel_i, wb_dat_i, keys} <= '0;
    good();
    cyc(7);
    rst_i <= 1'b0;
    cyc(1);
    rchk("ctrl reset", drive_alarm_pkg::CTRL_ADDR, 32'hffffffff, 32'h00000001);
    rchk("level reset", drive_alarm_pkg::LEVEL_ADDR, 32'hffffffff, 32'h00000800);
    rchk("still reset", drive_alarm_pkg::STILL_ADDR, 32'hffffffff, 32'h00000020);
    xfer(1'b1, 8'h40, 32'hffffffff);
    rchk("unmapped", 8'h40, 32'hffffffff, 32'h00000000);
    rchk("health up", drive_alarm_pkg::STATUS_ADDR, 32'h00020000, 32'h00020000);
    $display("test reset values done");
    for (int i = 0; i < 24; i++) begin
      good();
      case (act[i])
        1: sync_ok_i <= 1'b0;
        2: supply_freq_i <= val[i];
        3: tach_ok_i <= 1'b0;
        4: fibre_ok_i <= 1'b0;
        5: speed_fbk_i <= val[i];
        6: stack_switch_open_i <= 1'b1;
        7: net_rx_ok_i <= 1'b0;
        8: net_if_ok_i <= 1'b0;
        9: field_current_i <= val[i];
        10: armature_voltage_i <= val[i];
        11: supply_ok_i <= 1'b0;
        default: ;
      endcase
      xfer(1'b1, drive_alarm_pkg::CTRL_ADDR, {24'h0, ctl[i]});
      smp();
      rchk("alarms", drive_alarm_pkg::STATUS_ADDR, 32'hffff, {16'h0, exp[i]});
      chk("health idle", health_o, 1'b1);
    end
    $display("test alarm table done");
    good();
    xfer(1'b1, drive_alarm_pkg::CTRL_ADDR, 32'h1c);
    restart();
    chk("energised", contactor_o, 1'b1);
    chk("firing on", fire_en_o, 1'b1);
    {speed_fbk_i, armature_voltage_i} <= {16'h0ce5, 16'h0ce5};
    smp();
    chk("health trip", health_o, 1'b0);
    chk("contactor trip", contactor_o, 1'b0);
    chk("firing off", fire_en_o, 1'b0);
    rchk("first", drive_alarm_pkg::FIRST_ADDR, 32'h1f, 32'h1e);
    good();
    sync_ok_i <= 1'b0;
    smp();
    rchk("first kept", drive_alarm_pkg::FIRST_ADDR, 32'h1f, 32'h1e);
    good();
    restart();
    chk("health back", {health_o, contactor_o}, 2'h3);
    rchk("latch clear", drive_alarm_pkg::FIRST_ADDR, 32'h10, 32'h0);
    supply_ok_i <= 1'b0;
    smp();
    rchk("first supply", drive_alarm_pkg::FIRST_ADDR, 32'h1f, 32'h15);
    restart();
    chk("re-energised", contactor_o, 1'b1);
    smp();
    chk("drop again", contactor_o, 1'b0);
    good();
    stack_switch_open_i <= 1'b1;
    restart();
    chk("stack blocks", contactor_o, 1'b0);
    good();
    restart();
    chk("stack closed", contactor_o, 1'b1);
    good();
    cal_card_in_i <= 1'b0;
    restart();
    smp();
    rchk("cal card", drive_alarm_pkg::STATUS_ADDR, 32'h0400, 32'h0400);
    chk("cal trip", contactor_o, 1'b0);
    good();
    restart();
    start_i <= 1'b0;
    $display("test latch and restart done");
    slow <= 1'b1;
    press(0);
    chk("prompt", {save_prompt_o, saving_o}, 2'h2);
    for (int s = 0; s < 2; s++) begin
      press(1);
      chk("saving", {save_prompt_o, saving_o}, 2'h1);
      rchk("bus busy save", drive_alarm_pkg::STATUS_ADDR, 32'h00120000, 32'h00120000);
      for (int k = 0; k < 100 && save_prompt_o !== 1'b1; k++) cyc(1);
      cyc(1);
      chk("prompt back", {save_prompt_o, saving_o}, 2'h2);
      slow <= 1'b0;
    end
    rchk("save count", drive_alarm_pkg::SAVES_ADDR, 32'hffff, 32'h2);
    press(2);
    chk("menu left", save_prompt_o, 1'b0);
    $display("test parameter save done");
    end_of_test();
  end
endmodule : tb
